// ### char_translate.sv
// character translation table with word-marker strip and invalid check
`timescale 1ns/1ps
module char_translate
#(
	parameter int IDX_W = 9 // direction bit plus character byte
)
(
	input  wire logic             core_clk, // system clock
	input  wire logic             reset,    // synchronous, active high
	input  wire logic             tbl_wr,   // table entry write strobe
	input  wire logic [IDX_W-1:0] tbl_addr, // entry index for writes
	input  wire logic [7:0]       tbl_data, // entry value
	input  wire logic             xl_req,   // lookup request pulse
	input  wire logic             xl_dir,   // 1: internal to decimal
	input  wire logic [7:0]       xl_char,  // character to translate
	output logic                  xl_valid, // result pulse, one cycle after request
	output logic [7:0]            xl_data   // translated character
);
	import legacy_mode_pkg::*;

	logic [7:0]       table_mem [2**IDX_W];
	logic [IDX_W-1:0] idx;
	logic [7:0]       entry;
	logic [7:0]       nxt_data;
	logic [7:0]       data_ff;
	logic             valid_ff;

	// ----------------------------------------
	// index and lookup
	// ----------------------------------------
	// forcing bit 1 on makes marked and unmarked forms share one entry
	always_comb
	begin
		idx   = {xl_dir, xl_char | WM_BIT_MASK};
		entry = table_mem[idx];
		nxt_data = entry;
		if (xl_dir && entry == INVALID_DECIMAL)
			nxt_data = DECIMAL_BLANK;
	end

	// table is plain storage; loaded by software before use
	always_ff @(posedge core_clk)
	begin
		if (tbl_wr)
			table_mem[tbl_addr] <= tbl_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			valid_ff <= 1'b0;
			data_ff  <= DECIMAL_BLANK;
		end
		else
		begin
			valid_ff <= xl_req;
			data_ff  <= xl_req ? nxt_data : data_ff;
		end
	end

	assign xl_valid = valid_ff;
	assign xl_data  = data_ff;
endmodule

// ### legacy_mode_ctrl.sv
// legacy mode control, pointer gating, sense switches and character translation
`timescale 1ns/1ps
module legacy_mode_ctrl
(
	input  wire logic        core_clk,                 // 50 MHz system clock
	input  wire logic        reset,                    // system reset, synchronous, active high
	input  wire logic [7:0]  reg_addr,                 // register byte address
	input  wire logic [31:0] reg_wdata,                // register write data
	input  wire logic        reg_wr,                   // write strobe
	input  wire logic        reg_rd,                   // read strobe
	output logic      [31:0] reg_rdata,                // read data, cycle after strobe
	input  wire logic [3:0]  rotary_switch_pin,        // console rotary select switch
	input  wire logic        mode_load_key_pin,        // console mode load key
	input  wire logic        interrupt_key_pin,        // console interrupt key
	input  wire logic        start_key_pin,            // console start key
	input  wire logic        uv_to_wx_stb,             // pointer pair to extension register
	input  wire logic [7:0]  upper_source_byte,        // upper byte of that transfer
	input  wire logic        alt_to_wx_stb,            // alternate-source extension load
	input  wire logic        adder_input_high_bit,     // high adder input bit
	input  wire logic        other_half_to_wx_stb,     // other-half extension load
	input  wire logic        recycle_reset,            // recycle reset pulse
	input  wire logic        priority_trap,            // priority trap pulse
	input  wire logic [15:0] instruction_pointer_pair, // instruction pointer pair
	input  wire logic [15:0] legacy_b_pointer_pair,    // b pointer pair
	input  wire logic [15:0] legacy_a_pointer_pair,    // a pointer pair
	input  wire logic        sar_load_stb,             // storage address destination strobe
	input  wire logic [3:0]  sar_src_sel,              // source code of that microword
	output logic             legacy_mode_bit,          // legacy mode state
	output logic             microcode_bank_sel,       // 1 selects the extra microcode store
	output logic      [15:0] storage_address_register, // storage address
	output logic      [15:0] instr_counter,            // active instruction counter
	output logic      [15:0] b_address,                // active b address
	output logic      [15:0] a_address,                // active a address
	output logic      [7:0]  storage_data_display,     // storage data register display
	output logic      [7:0]  a_reg_display,            // a register display
	output logic             cpu_halted                // processor halted
);
	import legacy_mode_pkg::*;

	// ----------------------------------------
	// console pin synchronisers
	// ----------------------------------------
	logic [6:0] pins_lvl;
	logic [3:0] dial;
	logic       load_lvl, intr_lvl, start_lvl;
	logic       load_q_ff, intr_q_ff, start_q_ff;
	logic       load_edge, intr_edge, start_edge;

	pin_sync #(.WIDTH(7)) u_pins
	(
		.core_clk  (core_clk),
		.reset     (reset),
		.pin_in    ({rotary_switch_pin, mode_load_key_pin, interrupt_key_pin, start_key_pin}),
		.level_out (pins_lvl)
	);

	assign dial      = pins_lvl[6:3];
	assign load_lvl  = pins_lvl[2];
	assign intr_lvl  = pins_lvl[1];
	assign start_lvl = pins_lvl[0];
	assign load_edge  = load_lvl & ~load_q_ff;
	assign intr_edge  = intr_lvl & ~intr_q_ff;
	assign start_edge = start_lvl & ~start_q_ff;

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			load_q_ff  <= 1'b0;
			intr_q_ff  <= 1'b0;
			start_q_ff <= 1'b0;
		end
		else
		begin
			load_q_ff  <= load_lvl;
			intr_q_ff  <= intr_lvl;
			start_q_ff <= start_lvl;
		end
	end

	// ----------------------------------------
	// legacy mode bit
	// ----------------------------------------
	logic mode_ff, nxt_mode;
	logic bank_ff;

	// recycle reset, other-half load and traps have no path here on purpose
	always_comb
	begin
		nxt_mode = mode_ff;
		if (load_edge)
			nxt_mode = dial[0];
		else if (uv_to_wx_stb)
			nxt_mode = upper_source_byte[UPPER_BIT3_POS];
		else if (alt_to_wx_stb)
			nxt_mode = adder_input_high_bit;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			mode_ff <= 1'b0;
			bank_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			bank_ff <= nxt_mode;
		end
	end

	// ----------------------------------------
	// pointer pairs and storage address
	// ----------------------------------------
	logic [15:0] sar_ff, nxt_sar;
	logic [15:0] ic_ff, nxt_ic, ba_ff, nxt_ba, aa_ff, nxt_aa;

	always_comb
	begin
		nxt_sar = sar_ff;
		nxt_ic  = ic_ff;
		nxt_ba  = ba_ff;
		nxt_aa  = aa_ff;
		if (mode_ff)
		begin
			nxt_ic = instruction_pointer_pair;
			nxt_ba = legacy_b_pointer_pair;
			nxt_aa = legacy_a_pointer_pair;
		end
		if (sar_load_stb)
		begin
			case (sar_src_sel)
				SRC_IP_PAIR: nxt_sar = instruction_pointer_pair;
				SRC_B_PAIR:  nxt_sar = legacy_b_pointer_pair;
				// native mode moves the named byte only; legacy gates the pair
				SRC_A_LO:    nxt_sar = mode_ff ? legacy_a_pointer_pair
				                               : {sar_ff[15:8], legacy_a_pointer_pair[7:0]};
				default:     nxt_sar = sar_ff;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sar_ff <= PAIR_RESET_VAL;
			ic_ff  <= PAIR_RESET_VAL;
			ba_ff  <= PAIR_RESET_VAL;
			aa_ff  <= PAIR_RESET_VAL;
		end
		else
		begin
			sar_ff <= nxt_sar;
			ic_ff  <= nxt_ic;
			ba_ff  <= nxt_ba;
			aa_ff  <= nxt_aa;
		end
	end

	// ----------------------------------------
	// sense switches and halt
	// ----------------------------------------
	run_state_t  st_ff, nxt_st;
	logic [7:0]  sense_ff, nxt_sense;
	logic [7:0]  sdr_ff, nxt_sdr;
	logic [7:0]  areg_ff, nxt_areg;
	logic        sw_wr_sense;

	assign sw_wr_sense = reg_wr && reg_addr == OFF_SENSE;

	// dial letters sit in the upper half; the opposite position is the same low three bits
	always_comb
	begin
		nxt_st    = st_ff;
		nxt_sense = sense_ff;
		nxt_sdr   = sdr_ff;
		nxt_areg  = areg_ff;
		if (sw_wr_sense)
			nxt_sense = reg_wdata[7:0];
		case (st_ff)
			ST_RUN:
			begin
				if (intr_edge && mode_ff)
				begin
					nxt_sense[dial[2:0]] = dial[3];
					nxt_sdr  = SENSE_DONE_PAT;
					nxt_areg = nxt_sense;
					nxt_st   = ST_SENSE_HLT;
				end
			end
			ST_SENSE_HLT:
			begin
				if (start_edge)
					nxt_st = ST_RUN;
			end
			default: nxt_st = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_ff    <= ST_RUN;
			sense_ff <= SENSE_RESET_VAL;
			sdr_ff   <= SENSE_RESET_VAL;
			areg_ff  <= SENSE_RESET_VAL;
		end
		else
		begin
			st_ff    <= nxt_st;
			sense_ff <= nxt_sense;
			sdr_ff   <= nxt_sdr;
			areg_ff  <= nxt_areg;
		end
	end

	// ----------------------------------------
	// translation table and register port
	// ----------------------------------------
	logic [8:0]  tptr_ff, nxt_tptr;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [7:0]  xl_res_ff, nxt_xl_res;
	logic        xl_done_ff, nxt_xl_done;
	logic        tbl_wr, xl_req, xl_valid;
	logic [7:0]  xl_data;

	assign tbl_wr = reg_wr && reg_addr == OFF_TBL_DATA;
	assign xl_req = reg_wr && reg_addr == OFF_XLATE;

	char_translate #(.IDX_W(9)) u_xlate
	(
		.core_clk (core_clk),
		.reset    (reset),
		.tbl_wr   (tbl_wr),
		.tbl_addr (tptr_ff),
		.tbl_data (reg_wdata[7:0]),
		.xl_req   (xl_req),
		.xl_dir   (reg_wdata[XL_DIR_BIT]),
		.xl_char  (reg_wdata[7:0]),
		.xl_valid (xl_valid),
		.xl_data  (xl_data)
	);

	// result flag stays until the next lookup starts; a new result wins over that clear
	always_comb
	begin
		nxt_tptr    = tptr_ff;
		nxt_xl_res  = xl_res_ff;
		nxt_xl_done = xl_done_ff;
		nxt_rdata   = RDATA_RESET_VAL;
		if (reg_wr && reg_addr == OFF_TBL_ADDR)
			nxt_tptr = reg_wdata[8:0];
		else if (tbl_wr)
			nxt_tptr = tptr_ff + 9'h001;
		if (xl_req)
			nxt_xl_done = 1'b0;
		if (xl_valid)
		begin
			nxt_xl_done = 1'b1;
			nxt_xl_res  = xl_data;
		end
		if (reg_rd)
		begin
			case (reg_addr)
				OFF_STATUS:   nxt_rdata = {30'h0, st_ff == ST_SENSE_HLT, mode_ff};
				OFF_SENSE:    nxt_rdata = {24'h0, sense_ff};
				OFF_TBL_ADDR: nxt_rdata = {23'h0, tptr_ff};
				OFF_XLATE:    nxt_rdata = {xl_done_ff, 23'h0, xl_res_ff};
				default:      nxt_rdata = RDATA_RESET_VAL;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			tptr_ff    <= 9'h000;
			xl_res_ff  <= DECIMAL_BLANK;
			xl_done_ff <= 1'b0;
			rdata_ff   <= RDATA_RESET_VAL;
		end
		else
		begin
			tptr_ff    <= nxt_tptr;
			xl_res_ff  <= nxt_xl_res;
			xl_done_ff <= nxt_xl_done;
			rdata_ff   <= nxt_rdata;
		end
	end

	assign reg_rdata                = rdata_ff;
	assign legacy_mode_bit          = mode_ff;
	assign microcode_bank_sel       = bank_ff;
	assign storage_address_register = sar_ff;
	assign instr_counter            = ic_ff;
	assign b_address                = ba_ff;
	assign a_address                = aa_ff;
	assign storage_data_display     = sdr_ff;
	assign a_reg_display            = areg_ff;
	assign cpu_halted               = (st_ff == ST_SENSE_HLT);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	AST_BANK_FOLLOWS: assert property (microcode_bank_sel == legacy_mode_bit)
		else $error("bank select differs from mode bit");
	AST_CONSOLE_LOAD: assert property (load_edge |=> legacy_mode_bit == $past(dial[0]))
		else $error("console load did not follow dial parity");
	AST_UV_LOAD: assert property (!load_edge && uv_to_wx_stb |=> legacy_mode_bit == $past(upper_source_byte[4]))
		else $error("pair transfer did not copy bit three");
	AST_ALT_LOAD: assert property (!load_edge && !uv_to_wx_stb && alt_to_wx_stb
		|=> legacy_mode_bit == $past(adder_input_high_bit))
		else $error("alternate load did not copy adder bit");
	AST_MODE_HOLD: assert property (!load_edge && !uv_to_wx_stb && !alt_to_wx_stb
		&& (recycle_reset || other_half_to_wx_stb || priority_trap) |=> $stable(legacy_mode_bit))
		else $error("mode bit changed by a neutral event");
	AST_RESET_CLEAR: assert property (@(posedge core_clk) disable iff (1'b0) reset |=> !legacy_mode_bit)
		else $error("system reset left mode bit on");
	AST_A_PAIR_GATE: assert property (sar_load_stb && sar_src_sel == SRC_A_LO && legacy_mode_bit
		|=> storage_address_register == $past(legacy_a_pointer_pair))
		else $error("a pair not gated whole");
	AST_IC_TRACK: assert property (legacy_mode_bit ##1 legacy_mode_bit
		|-> instr_counter == $past(instruction_pointer_pair))
		else $error("instruction counter not tracking pointer pair");
	AST_SENSE_SHOW: assert property ($rose(cpu_halted) |-> storage_data_display == 8'h77
		&& a_reg_display == sense_ff && sense_ff[$past(dial[2:0])] == $past(dial[3]))
		else $error("sense update display wrong");
	AST_HALT_HOLD: assert property (cpu_halted && !start_edge |=> cpu_halted)
		else $error("halt left without start key");
	AST_XLATE_TIME: assert property (xl_req |-> ##2 xl_done_ff)
		else $error("translation result late");
	AST_BLANK_OUT: assert property (xl_valid |-> xl_data != INVALID_DECIMAL || !$past(reg_wdata[8]))
		else $error("invalid decimal code delivered");

	COV_MODE_ON:  cover property (!legacy_mode_bit ##1 legacy_mode_bit);
	COV_SENSE:    cover property (cpu_halted ##[1:50] !cpu_halted);
	COV_PAIR_SAR: cover property (sar_load_stb && sar_src_sel == SRC_A_LO && legacy_mode_bit);
	COV_XLATE:    cover property (xl_valid && xl_data == DECIMAL_BLANK);
endmodule

// ### legacy_mode_pkg.sv
// constants shared by the legacy mode and character format logic
package legacy_mode_pkg;
	// ----------------------------------------
	// register map (byte offsets on the plain register port)
	// ----------------------------------------
	localparam logic [7:0] OFF_STATUS   = 8'h00; // mode bit, halt flag
	localparam logic [7:0] OFF_SENSE    = 8'h04; // sense-switch byte slot
	localparam logic [7:0] OFF_TBL_ADDR = 8'h08; // translation table pointer
	localparam logic [7:0] OFF_TBL_DATA = 8'h0C; // table entry write, pointer steps
	localparam logic [7:0] OFF_XLATE    = 8'h10; // write starts lookup, read gives result

	// ----------------------------------------
	// field positions and values
	// ----------------------------------------
	localparam int          STAT_MODE_BIT   = 0;
	localparam int          STAT_HALT_BIT   = 1;
	localparam int          XL_DIR_BIT      = 8;    // 1: internal to decimal
	localparam int          XL_VALID_BIT    = 31;
	localparam int          UPPER_BIT3_POS  = 4;    // bit 3 counted from the msb
	localparam logic [7:0]  WM_BIT_MASK     = 8'h40; // bit 1 counted from the msb, set = no marker
	localparam logic [7:0]  INVALID_DECIMAL = 8'h40;
	localparam logic [7:0]  DECIMAL_BLANK   = 8'h00;
	localparam logic [7:0]  SENSE_DONE_PAT  = 8'h77;
	localparam logic [7:0]  SENSE_RESET_VAL = 8'h00;
	localparam logic [15:0] PAIR_RESET_VAL  = 16'h0000;
	localparam logic [31:0] RDATA_RESET_VAL = 32'h0000_0000;

	// ----------------------------------------
	// storage address source codes from the microword
	// ----------------------------------------
	localparam logic [3:0] SRC_IP_PAIR = 4'h1;
	localparam logic [3:0] SRC_B_PAIR  = 4'h2;
	localparam logic [3:0] SRC_A_LO    = 4'h3; // low byte of the a pointer pair

	typedef enum logic [0:0]
	{
		ST_RUN       = 1'b0,
		ST_SENSE_HLT = 1'b1
	} run_state_t;
endpackage

// ### panel_seq_model.sv
// console panel and microprogram sequencer model driving the block's control inputs
`timescale 1ns/1ps
module panel_seq_model
(
	input  wire logic       core_clk,             // system clock
	output logic      [3:0] rotary_switch_pin,    // dial position
	output logic            mode_load_key_pin,    // mode load key
	output logic            interrupt_key_pin,    // interrupt key
	output logic            start_key_pin,        // start key
	output logic            uv_to_wx_stb,         // pointer pair transfer
	output logic      [7:0] upper_source_byte,    // upper byte of that transfer
	output logic            alt_to_wx_stb,        // alternate-source load
	output logic            adder_input_high_bit, // adder high input bit
	output logic            other_half_to_wx_stb, // other-half load
	output logic            recycle_reset,        // recycle reset pulse
	output logic            priority_trap,        // priority trap pulse
	output logic            sar_load_stb,         // storage address load
	output logic      [3:0] sar_src_sel           // source code of that microword
);
	// ----------------------------------------
	// operator and sequencer actions
	// ----------------------------------------
	// everything idle at time zero
	initial
	begin
		{rotary_switch_pin, mode_load_key_pin, interrupt_key_pin, start_key_pin} = '0;
		{uv_to_wx_stb, upper_source_byte, alt_to_wx_stb, adder_input_high_bit} = '0;
		{other_half_to_wx_stb, recycle_reset, priority_trap, sar_load_stb, sar_src_sel} = '0;
	end

	// dial settles before the key; the key is held long enough to pass the pin filter
	task automatic console_op(input int key, input logic [3:0] dial);
		@(posedge core_clk);
		rotary_switch_pin <= dial;
		repeat (6) @(posedge core_clk);
		mode_load_key_pin <= (key == 0);
		interrupt_key_pin <= (key == 1);
		start_key_pin     <= (key == 2);
		repeat (8) @(posedge core_clk);
		{mode_load_key_pin, interrupt_key_pin, start_key_pin} <= 3'h0;
		repeat (8) @(posedge core_clk);
		#1;
	endtask

	// one-cycle microword strobe: 0 uv, 1 alt, 2 other half, 3 recycle, 4 trap, 5 storage address
	task automatic micro_op(input int kind, input logic [7:0] val);
		@(posedge core_clk);
		upper_source_byte    <= val;
		adder_input_high_bit <= val[0];
		sar_src_sel          <= val[3:0];
		uv_to_wx_stb         <= (kind == 0);
		alt_to_wx_stb        <= (kind == 1);
		other_half_to_wx_stb <= (kind == 2);
		recycle_reset        <= (kind == 3);
		priority_trap        <= (kind == 4);
		sar_load_stb         <= (kind == 5);
		@(posedge core_clk);
		// released qualifiers flip so a late sample cannot pass by luck
		upper_source_byte    <= ~val;
		adder_input_high_bit <= ~val[0];
		sar_src_sel          <= ~val[3:0];
		{uv_to_wx_stb, alt_to_wx_stb, other_half_to_wx_stb} <= 3'h0;
		{recycle_reset, priority_trap, sar_load_stb} <= 3'h0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
endmodule

// ### pin_sync.sv
// three-stage synchroniser with agreement filter for console pins
`timescale 1ns/1ps
module pin_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             core_clk, // system clock
	input  wire logic             reset,    // synchronous, active high
	input  wire logic [WIDTH-1:0] pin_in,   // asynchronous pin levels
	output logic      [WIDTH-1:0] level_out // filtered level
);
	// ----------------------------------------
	// per-bit stages
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			logic s1_ff, s2_ff, s3_ff, lvl_ff;
			logic nxt_lvl;
			// only s2 and s3 are compared; s1 may be metastable
			always_comb
			begin
				nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
			end
			always_ff @(posedge core_clk)
			begin
				if (reset)
				begin
					s1_ff  <= 1'b0;
					s2_ff  <= 1'b0;
					s3_ff  <= 1'b0;
					lvl_ff <= 1'b0;
				end
				else
				begin
					s1_ff  <= pin_in[g];
					s2_ff  <= s1_ff;
					s3_ff  <= s2_ff;
					lvl_ff <= nxt_lvl;
				end
			end
			assign level_out[g] = lvl_ff;
		end
	endgenerate
endmodule

// ### testbench.sv
// self-checking testbench for the legacy mode control block
`timescale 1ns/1ps
module testbench;
	import legacy_mode_pkg::*;
	logic        core_clk;
	logic        reset;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [3:0]  dial;
	logic        mode_key, intr_key, start_key, uv_stb, alt_stb, adder_bit;
	logic        half_stb, recycle, trap, sar_stb;
	logic [7:0]  upper_byte;
	logic [3:0]  sar_src;
	logic [15:0] ip_pair, b_pair, a_pair, sar, icount, baddr, aaddr;
	logic        mode_bit, bank_sel, halted;
	logic [7:0]  sdr_disp, areg_disp;
	logic [31:0] rd_val;
	int          fails;
	int          comparisons;
	int          cycles;
	localparam logic [16:0] XCASE [6] = '{17'h1C333, 17'h18333, 17'h1C400, 17'h18400, 17'h033C3, 17'h07540};

	legacy_mode_ctrl uut
	(
		.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rotary_switch_pin(dial),
		.mode_load_key_pin(mode_key), .interrupt_key_pin(intr_key), .start_key_pin(start_key),
		.uv_to_wx_stb(uv_stb), .upper_source_byte(upper_byte), .alt_to_wx_stb(alt_stb),
		.adder_input_high_bit(adder_bit), .other_half_to_wx_stb(half_stb), .recycle_reset(recycle),
		.priority_trap(trap), .instruction_pointer_pair(ip_pair), .legacy_b_pointer_pair(b_pair),
		.legacy_a_pointer_pair(a_pair), .sar_load_stb(sar_stb), .sar_src_sel(sar_src),
		.legacy_mode_bit(mode_bit), .microcode_bank_sel(bank_sel), .storage_address_register(sar),
		.instr_counter(icount), .b_address(baddr), .a_address(aaddr), .storage_data_display(sdr_disp),
		.a_reg_display(areg_disp), .cpu_halted(halted)
	);

	panel_seq_model panel
	(
		.core_clk(core_clk), .rotary_switch_pin(dial), .mode_load_key_pin(mode_key),
		.interrupt_key_pin(intr_key), .start_key_pin(start_key), .uv_to_wx_stb(uv_stb),
		.upper_source_byte(upper_byte), .alt_to_wx_stb(alt_stb), .adder_input_high_bit(adder_bit),
		.other_half_to_wx_stb(half_stb), .recycle_reset(recycle), .priority_trap(trap),
		.sar_load_stb(sar_stb), .sar_src_sel(sar_src)
	);

	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;

	// a hung handshake would otherwise run forever
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			fails++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (fails == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// a gap cycle after each strobe keeps one assignment per signal per edge
	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		@(posedge core_clk);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
		@(posedge core_clk);
		reg_addr <= addr;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		data = reg_rdata;
	endtask

	task automatic set_pairs(input logic [15:0] ip, input logic [15:0] b, input logic [15:0] a);
		@(posedge core_clk);
		ip_pair <= ip;
		b_pair  <= b;
		a_pair  <= a;
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		fails = 0;
		comparisons = 0;
		cycles = 0;
		reset = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{ip_pair, b_pair, a_pair} = '0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check("mode after reset", mode_bit, 1'b0);
		reg_read(OFF_STATUS, rd_val);
		check("status after reset", rd_val, 32'h0000_0000);
		// every dial position, odd turns the mode on
		for (int d = 0; d < 16; d++)
		begin
			panel.console_op(0, d[3:0]);
			check("mode from dial", mode_bit, d[0]);
			check("bank select", bank_sel, d[0]);
		end
		panel.micro_op(0, 8'hEF);
		check("mode from upper byte", mode_bit, 1'b0);
		panel.micro_op(0, 8'h10);
		check("mode from upper byte", mode_bit, 1'b1);
		panel.micro_op(1, 8'hFE);
		check("mode from adder bit", mode_bit, 1'b0);
		// neutral pulses must not disturb either mode state
		for (int m = 0; m < 2; m++)
		begin
			panel.micro_op(1, m[7:0]);
			for (int k = 2; k < 5; k++)
			begin
				panel.micro_op(k, 8'h00);
				check("mode kept", mode_bit, m[0]);
			end
		end
		set_pairs(16'h1234, 16'h5678, 16'hA55A);
		check("instr counter", icount, 16'h1234);
		check("b address", baddr, 16'h5678);
		check("a address", aaddr, 16'hA55A);
		for (int s = 1; s < 4; s++)
		begin
			panel.micro_op(5, s[7:0]);
			check("storage address", sar, s == 1 ? 16'h1234 : s == 2 ? 16'h5678 : 16'hA55A);
		end
		panel.micro_op(5, 8'h00);
		check("storage address held", sar, 16'hA55A);
		// native mode: pointer outputs freeze
		panel.micro_op(1, 8'h00);
		set_pairs(16'h0F0F, 16'hF0F0, 16'h3C3C);
		check("instr counter held", icount, 16'h1234);
		check("bank select native", bank_sel, 1'b0);
		panel.micro_op(5, 8'h03);
		check("storage address native", sar, 16'hA53C);
		// translation table, marked and unmarked characters, invalid pattern
		reg_write(OFF_TBL_ADDR, 32'h0000_01C3);
		reg_write(OFF_TBL_DATA, 32'h0000_0033);
		reg_write(OFF_TBL_DATA, 32'h0000_0040);
		reg_write(OFF_TBL_ADDR, 32'h0000_0073);
		reg_write(OFF_TBL_DATA, 32'h0000_00C3);
		reg_write(OFF_TBL_ADDR, 32'h0000_0075);
		reg_write(OFF_TBL_DATA, 32'h0000_0040);
		foreach (XCASE[i])
		begin
			reg_write(OFF_XLATE, {23'h0, XCASE[i][16:8]});
			reg_read(OFF_XLATE, rd_val);
			check("translation", {rd_val[31], rd_val[7:0]}, {1'b1, XCASE[i][7:0]});
		end
		reg_read(8'h20, rd_val);
		check("unmapped read", rd_val, 32'h0000_0000);
		// sense switches set, ignored while halted, resumed, cleared
		reg_write(OFF_SENSE, 32'h0000_0081);
		panel.console_op(0, 4'h1);
		panel.console_op(1, 4'hC);
		check("halted after set", halted, 1'b1);
		reg_read(OFF_STATUS, rd_val);
		check("status while halted", rd_val, 32'h0000_0003);
		check("storage data display", sdr_disp, 8'h77);
		check("a register display", areg_disp, 8'h91);
		reg_read(OFF_SENSE, rd_val);
		check("sense slot", rd_val[7:0], 8'h91);
		panel.console_op(1, 4'h5);
		check("ignored while halted", areg_disp, 8'h91);
		panel.console_op(2, 4'h0);
		check("resumed", halted, 1'b0);
		panel.console_op(1, 4'h4);
		check("a register after clear", areg_disp, 8'h81);
		check("halted after clear", halted, 1'b1);
		// a second reset in mid-run leaves legacy mode
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		check("mode after second reset", mode_bit, 1'b0);
		check("bank after second reset", bank_sel, 1'b0);
		print_verdict();
	end
endmodule
